// *** hdl/lcx_cmd_exec.v ***
// command decoder and display controller of the segment driver
`timescale 1ns/1ps
`default_nettype none
`include "lcx_consts.vh"
module lcx_cmd_exec #(
    parameter DEPTH = 40
) (
    input  wire       i_clk_sys,
    input  wire       i_rst,
    input  wire       i_start,
    input  wire       i_byte_vld,
    input  wire [7:0] i_byte,
    input  wire [1:0] i_drive_mode,
    input  wire [2:0] i_hw_subaddr,
    input  wire [5:0] i_rd_addr,
    output reg  [5:0] o_ram_ptr,
    output reg  [2:0] o_sub_cnt,
    output reg        o_in_bank,
    output reg        o_out_bank,
    output reg  [1:0] o_blink_rate_sel,
    output reg        o_blink_alt,
    output reg        o_data_phase,
    output reg        o_ptr_valid,
    output reg        o_wr_pulse,
    output reg  [3:0] o_disp_bits,
    output wire [3:0] o_ram_rdata
);
    localparam SUB_BITS = 3;

    wire       is_cmd;
    wire       is_dat;
    wire       multi;
    wire       sel_me;
    wire       cmd_ptr;
    wire       cmd_sub;
    wire       cmd_bank;
    wire       cmd_blink;
    wire [2:0] hw_sub;
    wire [3:0] ram_q;
    reg  [3:0] next_wdata;
    reg  [3:0] next_wmask;
    reg  [5:0] next_ptr;
    reg  [3:0] raw;
    reg        we;
    reg        blink_style;

    // a start condition overrides whatever byte comes with it
    assign is_cmd    = i_byte_vld && !i_start && !o_data_phase;
    assign is_dat    = i_byte_vld && !i_start && o_data_phase &&
                       o_ptr_valid;
    assign multi     = (i_drive_mode == `LCX_MODE_MUX3) ||
                       (i_drive_mode == `LCX_MODE_MUX4);
    assign sel_me    = (o_sub_cnt == hw_sub);
    assign cmd_ptr   = !i_byte[6];
    assign cmd_sub   = (i_byte[6:3] == `LCX_SUB_PAT);
    assign cmd_bank  = (i_byte[6:2] == `LCX_BANK_PAT);
    assign cmd_blink = (i_byte[6:3] == `LCX_BLINK_PAT);
    assign o_ram_rdata = ram_q;

    // strap pins: three synchronizer flops per bit, taken into q when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < SUB_BITS; g = g + 1) begin : g_sub_sync
            reg s1;
            reg s2;
            reg s3;
            reg q;

            always @(posedge i_clk_sys) begin
                if (i_rst) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    q  <= 1'b0;
                end else begin
                    s1 <= i_hw_subaddr[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                        q <= s3;
                end
            end

            assign hw_sub[g] = q;
        end
    endgenerate

    // pack of the data bits into one ram nibble
    always @* begin
        next_wdata = 4'h0;
        next_wmask = 4'h0;
        case (i_drive_mode)
            `LCX_MODE_STATIC: begin
                next_wdata = o_in_bank ? {1'b0, i_byte[7], 2'b00}
                                       : {3'b000, i_byte[7]};
                next_wmask = o_in_bank ? 4'h4 : 4'h1;
            end
            `LCX_MODE_MUX2: begin
                next_wdata = o_in_bank ? {i_byte[6], i_byte[7], 2'b00}
                                       : {2'b00, i_byte[6], i_byte[7]};
                next_wmask = o_in_bank ? 4'hc : 4'h3;
            end
            `LCX_MODE_MUX3: begin
                next_wdata = {1'b0, i_byte[5], i_byte[6], i_byte[7]};
                next_wmask = 4'h7;
            end
            default: begin
                next_wdata = {i_byte[4], i_byte[5], i_byte[6], i_byte[7]};
                next_wmask = 4'hf;
            end
        endcase
        we = is_dat && sel_me;
    end

    // one address per byte; the wrap at the last address is below
    always @* begin
        next_ptr = o_ram_ptr + 6'h1;
    end

    // bit 7 of each command decides whether data follows
    always @(posedge i_clk_sys) begin
        if (i_rst)
            o_data_phase <= 1'b0;
        else if (i_start)
            o_data_phase <= 1'b0;
        else if (is_cmd)
            o_data_phase <= !i_byte[`LCX_CONT_BIT];
    end

    // ram pointer: loaded by command, advanced per data byte, stored here or not
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_ram_ptr   <= `LCX_RST_PTR;
            o_ptr_valid <= 1'b1;
        end else if (is_cmd && cmd_ptr) begin
            o_ram_ptr   <= i_byte[5:0];
            o_ptr_valid <= i_byte[5:0] <= `LCX_PTR_LAST;
        end else if (is_dat) begin
            if (o_ram_ptr == `LCX_PTR_LAST)
                o_ram_ptr <= `LCX_RST_PTR;
            else
                o_ram_ptr <= next_ptr;
        end
    end

    // subaddress counter: loaded by command, stepped when the pointer wraps
    always @(posedge i_clk_sys) begin
        if (i_rst)
            o_sub_cnt <= `LCX_RST_SUB;
        else if (is_cmd && cmd_sub)
            o_sub_cnt <= i_byte[2:0];
        else if (is_dat && o_ram_ptr == `LCX_PTR_LAST)
            o_sub_cnt <= o_sub_cnt + 3'h1;
    end

    // bank selects, frozen in 1:3 and 1:4 drive
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_in_bank  <= 1'b0;
            o_out_bank <= 1'b0;
        end else if (is_cmd && cmd_bank && !multi) begin
            o_in_bank  <= i_byte[1];
            o_out_bank <= i_byte[0];
        end
    end

    // blink rate and the style asked for by the last blink command
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_blink_rate_sel <= 2'b00;
            blink_style      <= 1'b0;
        end else if (is_cmd && cmd_blink) begin
            o_blink_rate_sel <= i_byte[1:0];
            blink_style      <= i_byte[2];
        end
    end

    // bank-alternating blink only exists in static and 1:2 drive
    always @(posedge i_clk_sys) begin
        if (i_rst)
            o_blink_alt <= 1'b0;
        else
            o_blink_alt <= blink_style && !multi;
    end

    // one-cycle marker of a byte stored by this device
    always @(posedge i_clk_sys) begin
        if (i_rst)
            o_wr_pulse <= 1'b0;
        else
            o_wr_pulse <= is_dat && sel_me;
    end

    // forty-word display ram
    lcx_ram_writer #(
        .DEPTH (DEPTH),
        .AW    (6)
    ) u_ram (
        .i_clk_sys (i_clk_sys),
        .i_we      (we),
        .i_addr    (o_ram_ptr),
        .i_wdata   (next_wdata),
        .i_wmask   (next_wmask),
        .i_raddr   (i_rd_addr),
        .o_rdata   (ram_q)
    );

    // display readout with output bank choice in static and 1:2 drive
    always @* begin
        raw = ram_q;
    end

    always @(posedge i_clk_sys) begin
        if (i_rst)
            o_disp_bits <= 4'h0;
        else if (multi)
            o_disp_bits <= raw;
        else
            o_disp_bits <= o_out_bank ? {2'b00, raw[3:2]}
                                      : {2'b00, raw[1:0]};
    end
endmodule // lcx_cmd_exec
`default_nettype wire

// *** hdl/lcx_consts.vh ***
// constants for the segment display command executor
`ifndef LCX_CONSTS_VH
`define LCX_CONSTS_VH
`define LCX_PTR_LAST      6'h27
`define LCX_SUB_PAT       4'hc
`define LCX_BANK_PAT      5'h1e
`define LCX_BLINK_PAT     4'he
`define LCX_MODE_STATIC   2'h1
`define LCX_MODE_MUX2     2'h2
`define LCX_MODE_MUX3     2'h3
`define LCX_MODE_MUX4     2'h0
`define LCX_CONT_BIT      7
`define LCX_RST_PTR       6'h00
`define LCX_RST_SUB       3'h0
`endif

// *** hdl/lcx_ram_writer.v ***
// display ram writer: one 4-bit word per address, masked nibble update
`timescale 1ns/1ps
`default_nettype none
module lcx_ram_writer #(
    parameter DEPTH = 40,
    parameter AW    = 6
) (
    input  wire          i_clk_sys,
    input  wire          i_we,
    input  wire [AW-1:0] i_addr,
    input  wire [3:0]    i_wdata,
    input  wire [3:0]    i_wmask,
    input  wire [AW-1:0] i_raddr,
    output reg  [3:0]    o_rdata
);
    reg [3:0] mem [0:DEPTH-1];

    always @(posedge i_clk_sys) begin
        if (i_we)
            mem[i_addr] <= (mem[i_addr] & ~i_wmask) | (i_wdata & i_wmask);
        o_rdata <= mem[i_raddr];
    end
endmodule // lcx_ram_writer
`default_nettype wire

// *** tb/lcx_cmd_exec_chk.sv ***
// assertion checker for the command executor
`timescale 1ns/1ps
`default_nettype none
module lcx_cmd_exec_chk (
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    input wire logic       i_start,
    input wire logic       i_byte_vld,
    input wire logic [7:0] i_byte,
    input wire logic [1:0] i_drive_mode,
    input wire logic [2:0] i_hw_subaddr,
    input wire logic [5:0] o_ram_ptr,
    input wire logic [2:0] o_sub_cnt,
    input wire logic       o_in_bank,
    input wire logic       o_out_bank,
    input wire logic [1:0] o_blink_rate_sel,
    input wire logic       o_blink_alt,
    input wire logic       o_data_phase,
    input wire logic       o_ptr_valid,
    input wire logic       o_wr_pulse
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    wire cmd = i_byte_vld && !i_start && !o_data_phase;
    wire dat = i_byte_vld && !i_start && o_data_phase && o_ptr_valid;
    wire bnk = cmd && i_byte[6:2] == 5'h1e;
    chk_ptr_load: assert property (cmd && !i_byte[6]
        |=> o_ram_ptr == $past(i_byte[5:0])) else $error("ptr load");
    chk_sub_load: assert property (cmd && i_byte[6:3] == 4'hc
        |=> o_sub_cnt == $past(i_byte[2:0])) else $error("sub load");
    chk_bank_set: assert property (bnk && ^i_drive_mode
        |=> {o_in_bank, o_out_bank} == $past(i_byte[1:0])) else $error("bank");
    chk_bank_hold: assert property (bnk && !(^i_drive_mode)
        |=> $stable({o_in_bank, o_out_bank})) else $error("bank hold");
    chk_blink_rate: assert property (cmd && i_byte[6:3] == 4'he
        |=> o_blink_rate_sel == $past(i_byte[1:0])) else $error("blink");
    chk_cont_flag: assert property (cmd
        |=> o_data_phase == !$past(i_byte[7])) else $error("cont");
    chk_ptr_adv: assert property (dat |=> o_ram_ptr ==
        ($past(o_ram_ptr) == 6'h27 ? 6'h00 : $past(o_ram_ptr) + 6'h01))
        else $error("ptr adv");
    chk_wr_sel: assert property (dat |=> o_wr_pulse ==
        ($past(o_sub_cnt) == $past(i_hw_subaddr))) else $error("write");
    chk_alt_multi: assert property (!(^$past(i_drive_mode))
        |-> !o_blink_alt) else $error("alt blink in multiplex");
    chk_wr_only_dat: assert property (o_wr_pulse
        |-> $past(dat)) else $error("write without data");
endmodule // lcx_cmd_exec_chk
`default_nettype wire

// *** tb/lcx_host.sv ***
// byte source standing in for the bus master
`timescale 1ns/1ps
`default_nettype none
module lcx_host (
    input  wire logic       i_clk_sys,
    output var  logic       o_start,
    output var  logic       o_vld,
    output var  logic [7:0] o_byte
);
    initial o_start = 1'b0;
    initial o_vld = 1'b0;
    initial o_byte = 8'h00;
    // one strobe per byte; bit 7 of commands chosen by caller
    task put(input logic [7:0] b, input logic s);
        @(posedge i_clk_sys) #1;
        {o_start, o_vld, o_byte} = {s, !s, b};
        @(posedge i_clk_sys) #1;
        {o_start, o_vld, o_byte} = {2'b00, ~b};
    endtask
endmodule // lcx_host
`default_nettype wire

// *** tb/lcx_cmd_exec_tb.sv ***
// testbench for the command executor
`timescale 1ns/1ps
`default_nettype none
module lcx_cmd_exec_tb;
    logic [7:0] i_byte;
    logic [5:0] i_rd_addr, o_ram_ptr;
    logic [3:0] o_disp_bits, o_ram_rdata;
    logic [2:0] i_hw_subaddr, o_sub_cnt;
    logic [1:0] i_drive_mode, o_blink_rate_sel;
    logic i_clk_sys, i_rst, i_start, i_byte_vld, o_in_bank, o_out_bank;
    logic o_blink_alt, o_data_phase, o_ptr_valid, o_wr_pulse;
    int n_fail = 0, comparisons = 0, cyc = 0;
    lcx_cmd_exec i_dut (.*);
    lcx_host i_host (.i_clk_sys, .o_start(i_start), .o_vld(i_byte_vld),
        .o_byte(i_byte));
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("Error %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("fails %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task t_cmds;
        chk({o_ram_ptr, o_in_bank, o_ptr_valid}, 8'h01);
        chk({o_sub_cnt, o_out_bank, o_blink_rate_sel}, 8'h00);
        i_host.put(8'h00, 1'b1);
        i_host.put(8'ha5, 1'b0);
        chk(o_ram_ptr, 8'h25);
        i_host.put(8'he3, 1'b0);
        chk(o_sub_cnt, 8'h03);
        for (int r = 0; r < 4; r++) begin
            i_host.put(8'hf0 | 8'(r), 1'b0);
            chk(o_blink_rate_sel, 8'(r));
        end
        i_host.put(8'hf4, 1'b0);
        @(posedge i_clk_sys) #1;
        chk({o_blink_alt, o_blink_rate_sel}, 8'h04);
        i_host.put(8'hfb, 1'b0);
        chk({o_in_bank, o_out_bank}, 8'h03);
        i_drive_mode = 2'h3;
        i_host.put(8'hf8, 1'b0);
        chk({o_in_bank, o_out_bank}, 8'h03);
        chk(o_blink_alt, 8'h00);
        i_drive_mode = 2'h1;
    endtask
    task t_data;
        i_host.put(8'h00, 1'b1);
        i_host.put(8'h27, 1'b0);
        chk(o_data_phase, 8'h01);
        i_host.put(8'hda, 1'b0);
        chk({o_wr_pulse, o_ram_ptr}, 8'h40);
        chk(o_sub_cnt, 8'h04);
        i_host.put(8'h33, 1'b0);
        chk({o_wr_pulse, o_ram_ptr}, 8'h01);
        i_rd_addr = 6'h27;
        repeat (2) @(posedge i_clk_sys) #1;
        chk({o_ram_rdata[2], o_disp_bits[0]}, 8'h03);
        i_drive_mode = 2'h3;
        @(posedge i_clk_sys) #1;
        chk(o_disp_bits[2], 8'h01);
        i_drive_mode = 2'h1;
        @(posedge i_clk_sys) #1;
        chk(o_blink_alt, 8'h01);
    endtask
    task t_bad;
        i_hw_subaddr = 3'h4;
        i_host.put(8'h00, 1'b1);
        i_host.put(8'h2a, 1'b0);
        chk(o_ptr_valid, 8'h00);
        i_host.put(8'h11, 1'b0);
        chk(o_wr_pulse, 8'h00);
    endtask
    initial begin
        {i_rst, i_drive_mode, i_hw_subaddr, i_rd_addr} = {1'b1, 5'h0b, 6'h00};
        repeat (20) @(posedge i_clk_sys);
        #1 i_rst = 1'b0;
        t_cmds();
        t_data();
        t_bad();
        stop_test();
    end
endmodule // lcx_cmd_exec_tb
bind lcx_cmd_exec lcx_cmd_exec_chk i_chk (.*);
`default_nettype wire
